// >>> logic/float_add_defines.svh
// constants for the decimal floating add/subtract sequencer
// Behaviour
// - operand is a variable-length mantissa, then a two-digit exponent
// - field's high end is found by the flag on the top mantissa digit
// - exponent is signed, -99 to +99; tens digit carries field flag
// - flag on a units digit means negative, no flag means positive
// - result sign follows ordinary algebraic sign rules
// - instruction: two-digit op code plus two five-digit addresses
// - operands are bounded only by flags; unflagged data is undefined; fetch stops after MAX_LEN mantissa digits
// - both addresses point at the exponent's low-order digit
// - results with leading zeros are normalized; inputs never checked
// - op code 01 adds second mantissa into first, result replaces first
// - equal exponents add with no shift
// - positive gap below length shifts second mantissa right, truncating
// - negative gap below length: first shifts right, second exponent taken
// - positive gap at or above length leaves first operand untouched
// - negative gap at or above length copies second operand over first
// - carry out shifts right, puts one on top, bumps first exponent
// - no carry: shift out leading zeros, exponent is second minus count
// - op code 02 is add with the second mantissa sign inverted
`ifndef FLOAT_ADD_DEFINES_SVH
`define FLOAT_ADD_DEFINES_SVH
`define FP_OP_ADD      8'h01
`define FP_OP_SUB      8'h02
`define FP_MAX_LEN     100
`define FP_MIN_LEN     2
`define FP_K_EXP_UNITS 7'h00
`define FP_K_EXP_TENS  7'h01
`define FP_K_MANT_LOW  7'h02
`define FP_K_MANT_END  7'h03
`define FP_DIGIT_MAX   5'h09
`define FP_RADIX       5'h0a
`define FP_ADDR_TEN    17'h0000a
`define FP_EXP_TEN     8'h0a
`define FP_ADDR_BITS   17
`endif

// >>> logic/float_add_pkg.sv
// types shared by the float add sequencer and its storage side
package float_add_pkg;
  // one storage position: flag bit over a bcd digit
  typedef struct packed {
    logic       flag;
    logic [3:0] value;
  } digit_t;
  // instruction word, all fields bcd
  typedef struct packed {
    logic [7:0]  op;
    logic [19:0] p_addr;
    logic [19:0] q_addr;
  } instr_t;
endpackage : float_add_pkg

// >>> logic/float_add_unit.sv
// digit-serial decimal floating add and subtract against core storage
`timescale 1ns/1ns
`include "float_add_defines.svh"
module float_add_unit #(
  parameter int MAX_LEN = `FP_MAX_LEN,
  parameter int ADDR_W  = `FP_ADDR_BITS
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // instruction
  input  wire logic                  start,
  input  wire float_add_pkg::instr_t instr,
  output logic                       busy,
  output logic                       done,
  output logic                       op_rejected,
  // core storage
  output logic [ADDR_W-1:0]          mem_addr,
  output logic                       rd_en,
  input  wire float_add_pkg::digit_t rd_data,
  output logic                       wr_en,
  output float_add_pkg::digit_t      wr_data
);
  import float_add_pkg::*;

  // refuse lengths the 7-bit counters or addresses cannot serve
  if (MAX_LEN < `FP_MIN_LEN || MAX_LEN > `FP_MAX_LEN ||
      ADDR_W < `FP_ADDR_BITS) begin : g_bad_param
    $error("parameter out of range");
  end

  typedef enum {IDLE, FETCH, DECIDE, ALIGN, ADD, RECOMP, NORM, WRITE, FIN}
    state_t;
  state_t state;

  logic [3:0]        pm [MAX_LEN];
  logic [3:0]        qm [MAX_LEN];
  logic [ADDR_W-1:0] pbase, qbase;
  logic [1:0]        phase;
  logic              sel_q, is_sub, pneg, qneg, rneg, carry, shift_p;
  logic [6:0]        k, len, cnt, zcnt;
  logic [7:0]        shamt;
  logic [3:0]        eu;
  logic              eneg;
  logic signed [8:0] pe, qe;

  // bcd address to binary, digit by digit
  function automatic logic [ADDR_W-1:0] to_bin(input logic [19:0] bcd);
    logic [ADDR_W-1:0] acc;
    acc = '0;
    for (int i = 4; i >= 0; i--) begin
      acc = ADDR_W'(acc * `FP_ADDR_TEN) + ADDR_W'(bcd[i*4 +: 4]);
    end
    return acc;
  endfunction : to_bin

  // alignment decision terms
  logic signed [8:0] gap, lens;
  logic              qeff, same_sign, last_dig, top_zero;
  assign gap       = pe - qe;
  assign lens      = $signed({2'b00, len});
  assign qeff      = qneg ^ is_sub;
  assign same_sign = (pneg == qeff);
  assign last_dig  = (cnt == len - 7'h01);
  assign top_zero  = (pm[len - 7'h01] == 4'h0);
  assign busy      = (state != IDLE);

  // one bcd digit of sum, difference or recomplement
  logic [4:0] t;
  logic [3:0] dig;
  logic       cout;
  always_comb begin
    t    = 5'h00;
    dig  = 4'h0;
    cout = 1'b0;
    if (state == ADD && same_sign) begin
      t = {1'b0, pm[cnt]} + {1'b0, qm[cnt]} + {4'h0, carry};
      if (t > `FP_DIGIT_MAX) begin
        dig  = 4'(t - `FP_RADIX);
        cout = 1'b1;
      end else begin
        dig = t[3:0];
      end
    end else begin
      if (state == RECOMP)
        t = 5'h00 - {1'b0, pm[cnt]} - {4'h0, carry};
      else
        t = {1'b0, pm[cnt]} - {1'b0, qm[cnt]} - {4'h0, carry};
      if (t[4]) begin
        dig  = 4'(t + `FP_RADIX);
        cout = 1'b1;
      end else begin
        dig = t[3:0];
      end
    end
  end

  // exponent digits for write-back
  logic [7:0] emag;
  assign emag = pe[8] ? 8'(-pe) : 8'(pe);

  // exponent magnitude as read: tens digit on the line, units held
  logic [7:0] emag_in;
  assign emag_in = {4'h0, rd_data.value} * `FP_EXP_TEN + {4'h0, eu};

  // sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= IDLE;
      phase <= 2'h0;
      k     <= 7'h00;
      sel_q <= 1'b0;
      len   <= 7'h00;
      cnt   <= 7'h00;
      zcnt  <= 7'h00;
      shamt <= 8'h00;
      carry <= 1'b0;
    end else begin
      unique case (state)
        IDLE: if (start) begin
          if (instr.op == `FP_OP_ADD || instr.op == `FP_OP_SUB) begin
            state <= FETCH;
            phase <= 2'h0;
            k     <= `FP_K_EXP_UNITS;
            sel_q <= 1'b0;
          end else begin
            state <= FIN;
          end
        end
        FETCH: begin
          phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
          if (phase == 2'h2) begin
            if ((k >= `FP_K_MANT_END && rd_data.flag) ||
                k == 7'(MAX_LEN + 1)) begin
              len   <= k - 7'h01;
              k     <= `FP_K_EXP_UNITS;
              sel_q <= 1'b1;
              if (sel_q)
                state <= DECIDE;
            end else begin
              k <= k + 7'h01;
            end
          end
        end
        DECIDE: begin
          cnt   <= 7'h00;
          carry <= 1'b0;
          if (gap >= lens)
            state <= FIN;
          else if (-gap >= lens)
            state <= WRITE;
          else begin
            state <= ALIGN;
            shamt <= gap[8] ? 8'(-gap) : gap[7:0];
          end
          k <= `FP_K_EXP_UNITS;
        end
        ALIGN: if (shamt != 8'h00)
          shamt <= shamt - 8'h01;
        else
          state <= ADD;
        ADD, RECOMP: begin
          carry <= cout;
          cnt   <= cnt + 7'h01;
          if (last_dig) begin
            cnt <= 7'h00;
            zcnt <= 7'h00;
            if (state == ADD && !same_sign && cout) begin
              state <= RECOMP;
              carry <= 1'b0;
            end else begin
              state <= NORM;
              carry <= (state == ADD) && same_sign && cout;
            end
          end
        end
        NORM: if (carry) begin
          state <= WRITE;
          carry <= 1'b0;
        end else if (top_zero && zcnt < len) begin
          zcnt <= zcnt + 7'h01;
        end else begin
          state <= WRITE;
        end
        WRITE: begin
          k <= k + 7'h01;
          if (k == len + 7'h01)
            state <= FIN;
        end
        FIN: state <= IDLE;
      endcase
    end
  end

  // storage address, strobes and write data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_addr    <= '0;
      rd_en       <= 1'b0;
      wr_en       <= 1'b0;
      wr_data     <= '0;
      done        <= 1'b0;
      op_rejected <= 1'b0;
    end else begin
      rd_en       <= (state == FETCH) && (phase == 2'h0);
      wr_en       <= (state == WRITE);
      done        <= (state == FIN);
      op_rejected <= (state == IDLE) && start && instr.op != `FP_OP_ADD &&
                     instr.op != `FP_OP_SUB;
      if (state == FETCH)
        mem_addr <= (sel_q ? qbase : pbase) - ADDR_W'(k);
      if (state == WRITE) begin
        mem_addr <= pbase - ADDR_W'(k);
        if (k == `FP_K_EXP_UNITS)
          wr_data <= '{flag: pe[8], value: 4'(emag % `FP_EXP_TEN)};
        else if (k == `FP_K_EXP_TENS)
          wr_data <= '{flag: 1'b1, value: 4'(emag / `FP_EXP_TEN)};
        else
          wr_data <= '{flag: (k == `FP_K_MANT_LOW && rneg) ||
                             (k == len + 7'h01),
                       value: pm[k - `FP_K_MANT_LOW]};
      end
    end
  end

  // operand signs, exponents and bases
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pbase <= '0;
      qbase <= '0;
      is_sub <= 1'b0;
      pneg <= 1'b0;
      qneg <= 1'b0;
      rneg <= 1'b0;
      eu <= 4'h0;
      eneg <= 1'b0;
      pe <= '0;
      qe <= '0;
    end else begin
      if (state == IDLE && start) begin
        pbase  <= to_bin(instr.p_addr);
        qbase  <= to_bin(instr.q_addr);
        is_sub <= (instr.op == `FP_OP_SUB);
      end
      if (state == FETCH && phase == 2'h2) begin
        if (k == `FP_K_EXP_UNITS) begin
          eu   <= rd_data.value;
          eneg <= rd_data.flag;
        end
        if (k == `FP_K_EXP_TENS) begin
          if (sel_q)
            qe <= eneg ? -$signed({1'b0, emag_in}) : $signed({1'b0, emag_in});
          else
            pe <= eneg ? -$signed({1'b0, emag_in}) : $signed({1'b0, emag_in});
        end
        if (k == `FP_K_MANT_LOW) begin
          if (sel_q)
            qneg <= rd_data.flag;
          else
            pneg <= rd_data.flag;
        end
      end
      if (state == DECIDE) begin
        rneg <= pneg;
        if (gap[8]) begin
          pe <= qe;
          if (-gap >= lens)
            rneg <= qeff;
        end
      end
      if (state == ADD && last_dig && !same_sign && cout)
        rneg <= qeff;
      if (state == NORM && carry)
        pe <= pe + 9'sh001;
      else if (state == NORM && !(top_zero && zcnt < len))
        pe <= qe - $signed({2'b00, zcnt});
    end
  end

  // mantissa digit arrays: load, align, add, normalize
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_p <= 1'b0;
      for (int i = 0; i < MAX_LEN; i++) begin
        pm[i] <= 4'h0;
        qm[i] <= 4'h0;
      end
    end else begin
      unique case (state)
        IDLE: for (int i = 0; i < MAX_LEN; i++) begin
          pm[i] <= 4'h0;
          qm[i] <= 4'h0;
        end
        FETCH: if (phase == 2'h2 && k >= `FP_K_MANT_LOW) begin
          if (sel_q)
            qm[k - `FP_K_MANT_LOW] <= rd_data.value;
          else
            pm[k - `FP_K_MANT_LOW] <= rd_data.value;
        end
        DECIDE: begin
          shift_p <= gap[8];
          if (-gap >= lens)
            for (int i = 0; i < MAX_LEN; i++) pm[i] <= qm[i];
        end
        ALIGN: if (shamt != 8'h00) begin
          for (int i = 0; i < MAX_LEN - 1; i++) begin
            if (shift_p)
              pm[i] <= pm[i + 1];
            else
              qm[i] <= qm[i + 1];
          end
          if (shift_p)
            pm[MAX_LEN - 1] <= 4'h0;
          else
            qm[MAX_LEN - 1] <= 4'h0;
        end
        ADD, RECOMP: pm[cnt] <= dig;
        NORM: if (carry) begin
          for (int i = 0; i < MAX_LEN - 1; i++) pm[i] <= pm[i + 1];
          pm[MAX_LEN - 1] <= 4'h0;
          pm[len - 7'h01] <= 4'h1;
        end else if (top_zero && zcnt < len) begin
          for (int i = MAX_LEN - 1; i > 0; i--) pm[i] <= pm[i - 1];
          pm[0] <= 4'h0;
        end
        default: ;
      endcase
    end
  end

  // checks
  property p_rd_single;
    @(posedge clk) disable iff (sys_rst) rd_en |=> !rd_en ##1 !rd_en;
  endproperty
  a_rd_single: assert property (p_rd_single)
    else $error("rd_en not single");
  property p_tens_flag;
    @(posedge clk) disable iff (sys_rst)
      (state == WRITE && k == `FP_K_EXP_TENS) |=> wr_en && wr_data.flag;
  endproperty
  a_tens_flag: assert property (p_tens_flag)
    else $error("tens flag lost");
  property p_top_flag;
    @(posedge clk) disable iff (sys_rst)
      (state == WRITE && k == len + 7'h01) |=> wr_data.flag ##1 state == IDLE;
  endproperty
  a_top_flag: assert property (p_top_flag)
    else $error("top flag lost");
  property p_write_addr;
    @(posedge clk) disable iff (sys_rst)
      (state == WRITE) |=> mem_addr == pbase - ADDR_W'($past(k));
  endproperty
  a_write_addr: assert property (p_write_addr)
    else $error("bad write address");
  property p_skip_no_write;
    @(posedge clk) disable iff (sys_rst)
      (state == DECIDE && gap >= lens) |=> !wr_en [*3];
  endproperty
  a_skip_no_write: assert property (p_skip_no_write)
    else $error("skip wrote");
  property p_bcd_out;
    @(posedge clk) disable iff (sys_rst) wr_en |-> wr_data.value <= 4'h9;
  endproperty
  a_bcd_out: assert property (p_bcd_out)
    else $error("non-decimal digit");
  property p_norm_top;
    @(posedge clk) disable iff (sys_rst)
      (state == NORM && !carry && zcnt < len) ##1 (state == WRITE) |->
        pm[len - 7'h01] != 4'h0;
  endproperty
  a_norm_top: assert property (p_norm_top)
    else $error("not normalized");
  property p_ovf_top;
    @(posedge clk) disable iff (sys_rst)
      (state == NORM && carry) |=> pm[len - 7'h01] == 4'h1 && state == WRITE;
  endproperty
  a_ovf_top: assert property (p_ovf_top)
    else $error("overflow top digit");
  property p_done_once;
    @(posedge clk) disable iff (sys_rst) done |=> !done && !busy;
  endproperty
  a_done_once: assert property (p_done_once)
    else $error("done not a pulse");
endmodule : float_add_unit

// >>> tb/core_store.sv
// behavioural core storage that answers the float add unit
`timescale 1ns/1ns
module core_store #(
  parameter int ADDR_W = 17
) (
  // clock
  input  wire logic                  clk,
  // storage port
  input  wire logic [ADDR_W-1:0]     mem_addr,
  input  wire logic                  rd_en,
  output float_add_pkg::digit_t      rd_data,
  input  wire logic                  wr_en,
  input  wire float_add_pkg::digit_t wr_data
);
  import float_add_pkg::*;
  digit_t cells [0:(2**ADDR_W)-1];
  digit_t last;
  logic   hold;

  // storage starts cleared
  initial begin
    for (int i = 0; i < 2**ADDR_W; i++) begin
      cells[i] = 5'h00;
    end
    last = 5'h00;
    hold = 1'b0;
  end

  // address taken at the edge ending a read strobe, data held one cycle
  always @(posedge clk) begin
    hold <= rd_en;
    if (rd_en) begin
      last <= cells[mem_addr];
    end
    if (wr_en) begin
      cells[mem_addr] <= wr_data;
    end
  end

  // outside the data cycle the line shows junk, not the last digit
  assign rd_data = hold ? last : ~last;
endmodule : core_store

// >>> tb/decimal_float_add_align_tb.sv
// self-checking bench for the decimal floating add and subtract unit
`timescale 1ns/1ns
module decimal_float_add_align_tb;
  import float_add_pkg::*;
  localparam logic [16:0] P_BIN = 17'h000c8;
  localparam logic [16:0] Q_BIN = 17'h0012c;
  logic        clk;
  logic        sys_rst;
  logic        start;
  instr_t      instr;
  logic        busy;
  logic        done;
  logic        op_rejected;
  logic [16:0] mem_addr;
  logic        rd_en;
  logic        wr_en;
  digit_t      rd_data;
  digit_t      wr_data;
  int          mismatches;
  int          comparisons;
  int          rd_seen;
  int          wr_seen;
  int          rej_seen;

  // unit under test and its storage
  float_add_unit i_dut (.clk(clk), .sys_rst(sys_rst), .start(start),
    .instr(instr), .busy(busy), .done(done), .op_rejected(op_rejected),
    .mem_addr(mem_addr), .rd_en(rd_en), .rd_data(rd_data), .wr_en(wr_en),
    .wr_data(wr_data));
  core_store i_mem (.clk(clk), .mem_addr(mem_addr), .rd_en(rd_en),
    .rd_data(rd_data), .wr_en(wr_en), .wr_data(wr_data));

  // 50 MHz clock
  always #10 clk = ~clk;

  // count storage strobes and refusals per operation
  always @(posedge clk) begin
    if (rd_en === 1'b1) rd_seen++;
    if (wr_en === 1'b1) wr_seen++;
    if (op_rejected === 1'b1) rej_seen++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask : check

  // field image: top mantissa digit first, exponent units last
  function automatic logic [24:0] fld(input logic [11:0] m, input int ms,
                                     input logic [7:0] e, input int es);
    return {1'b1, m[11:8], 1'b0, m[7:4], ms[0], m[3:0], 1'b1, e[7:4], es[0],
            e[3:0]};
  endfunction : fld

  task automatic put(input logic [16:0] base, input logic [24:0] f);
    for (int k = 0; k < 5; k++) begin
      i_mem.cells[base - 17'(k)] = f[k*5 +: 5];
    end
  endtask : put

  function automatic logic [24:0] get(input logic [16:0] base);
    logic [24:0] f;
    for (int k = 0; k < 5; k++) begin
      f[k*5 +: 5] = i_mem.cells[base - 17'(k)];
    end
    return f;
  endfunction : get

  // issue one instruction and wait for its completion pulse
  task automatic run_op(input logic [7:0] op);
    int n;
    rd_seen = 0;
    wr_seen = 0;
    rej_seen = 0;
    @(posedge clk);
    start <= 1'b1;
    instr <= '{op: op, p_addr: 20'h00200, q_addr: 20'h00300};
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    check(32'(n < 2000), 32'h1);
  endtask : run_op

  // load both operands, run, compare both fields afterwards
  task automatic arith(input string name, input logic [7:0] op,
                       input logic [24:0] p, input logic [24:0] q,
                       input logic [24:0] want);
    put(P_BIN, p);
    put(Q_BIN, q);
    run_op(op);
    check(32'(get(P_BIN)), 32'(want));
    check(32'(get(Q_BIN)), 32'(q));
    $display("test %s finished", name);
  endtask : arith

  task automatic t_equal;
    arith("equal", 8'h01, fld(12'h123, 0, 8'h04, 0), fld(12'h789, 0, 8'h04, 0),
          fld(12'h912, 0, 8'h04, 0));
    check(32'(wr_seen), 32'd5);
  endtask : t_equal

  task automatic t_carry;
    arith("carry", 8'h01, fld(12'h987, 0, 8'h02, 0), fld(12'h456, 0, 8'h01, 0),
          fld(12'h103, 0, 8'h03, 0));
  endtask : t_carry

  task automatic t_pshift;
    arith("pshift", 8'h01, fld(12'h123, 0, 8'h11, 0), fld(12'h789, 0, 8'h12, 0),
          fld(12'h801, 0, 8'h12, 0));
  endtask : t_pshift

  task automatic t_p_above;
    arith("p_above", 8'h01, fld(12'h123, 0, 8'h05, 0),
          fld(12'h789, 0, 8'h02, 0), fld(12'h123, 0, 8'h05, 0));
    check(32'(wr_seen), 32'd0);
  endtask : t_p_above

  task automatic t_q_above;
    arith("q_above", 8'h01, fld(12'h123, 0, 8'h01, 0),
          fld(12'h789, 0, 8'h04, 0), fld(12'h789, 0, 8'h04, 0));
  endtask : t_q_above

  task automatic t_norm;
    arith("norm", 8'h01, fld(12'h123, 0, 8'h01, 0), fld(12'h119, 1, 8'h01, 0),
          fld(12'h400, 0, 8'h01, 1));
  endtask : t_norm

  task automatic t_sub;
    arith("sub", 8'h02, fld(12'h200, 0, 8'h03, 1), fld(12'h500, 0, 8'h03, 1),
          fld(12'h300, 1, 8'h03, 1));
    arith("sub_copy", 8'h02, fld(12'h123, 0, 8'h01, 0),
          fld(12'h789, 0, 8'h04, 0), fld(12'h789, 1, 8'h04, 0));
  endtask : t_sub

  task automatic t_reject;
    put(P_BIN, fld(12'h123, 0, 8'h01, 0));
    run_op(8'h03);
    check(32'(rej_seen), 32'd1);
    check(32'(rd_seen + wr_seen), 32'd0);
    check(32'(get(P_BIN)), 32'(fld(12'h123, 0, 8'h01, 0)));
    $display("test reject finished");
  endtask : t_reject

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    start = 1'b0;
    instr = '0;
    mismatches = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    #1;
    check(32'({busy, done, rd_en, wr_en}), 32'h0);
    @(posedge clk);
    sys_rst <= 1'b0;
    t_equal();
    t_carry();
    t_pshift();
    t_p_above();
    t_q_above();
    t_norm();
    t_sub();
    t_reject();
    conclude();
  end
endmodule : decimal_float_add_align_tb
